// *** hw/isdrp_top.sv ***
// Request parser: buffer loaded over APB, commands walked and issued to the port unit
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Accept one or many commands, process each
// - Mixed command sizes up to payload size
// - Same field layout for reads and writes
// - Blocking: reply only after all commands
// - Non-blocking: acknowledge right after checking
// - Completion status only after all commands
// - Stop at control zero or data end
// - Swap nibble: none, 16-bit, 32-bit
// - Type nibble: nop, read, write, or, and
// - Control zero: final, length 1 to 232
// - Controls 1-7: fixed areas 4 to 232
// - Index addresses target data object
// - Subindex selects structured element
// - Nested length 1 to area size
// - Data span derived from control field
// - Data area follows every type; sent out only for write types
module isdrp_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   output var  logic        cmd_valid,
   output var  logic [3:0]  cmd_op,
   output var  logic [3:0]  cmd_swap,
   output var  logic [15:0] cmd_index,
   output var  logic [15:0] cmd_subindex,
   output var  logic [15:0] cmd_length,
   output var  logic        wdata_valid,
   output var  logic [7:0]  wdata_byte,
   input  wire logic        cmd_done,
   output var  logic        req_ack,
   output var  logic        req_busy
);
   //////////////////////////////////////////////////////////////////////////
   isdrp_pkg::isdrp_state_t state;
   logic [isdrp_pkg::BUF_AW-1:0] load_addr;
   logic [isdrp_pkg::BUF_AW:0]   req_len;
   logic [isdrp_pkg::BUF_AW:0]   rd_ptr;
   logic [isdrp_pkg::BUF_AW:0]   area_end;
   logic [isdrp_pkg::BUF_AW:0]   wr_end;
   logic [3:0]  hcnt;
   logic [7:0]  hdr [isdrp_pkg::HDR_BYTES];
   logic        nonblock;
   logic        done_flag;
   logic        err_flag;
   logic [15:0] cmd_count;
   logic [7:0]  mem_rdata;
   logic        rd_phase;

   // Little-endian 16-bit field from two header bytes
   function automatic logic [15:0] le16(input logic [7:0] lo, input logic [7:0] hi);
      le16 = {hi, lo};
   endfunction : le16

   wire logic acc      = psel & penable;
   wire logic setup    = psel & ~penable;
   wire logic wr_acc   = acc & pwrite;
   wire logic idle     = (state == isdrp_pkg::ST_IDLE);
   wire logic hit_ctrl = (paddr == isdrp_pkg::ADDR_CTRL);
   wire logic hit_len  = (paddr == isdrp_pkg::ADDR_REQ_LEN);
   wire logic hit_badr = (paddr == isdrp_pkg::ADDR_BUF_ADDR);
   wire logic hit_bdat = (paddr == isdrp_pkg::ADDR_BUF_DATA);
   wire logic hit_stat = (paddr == isdrp_pkg::ADDR_STATUS);
   wire logic hit_cmd0 = (paddr == isdrp_pkg::ADDR_CMD0);
   wire logic hit_cmd1 = (paddr == isdrp_pkg::ADDR_CMD1);
   wire logic hit_wdat = (paddr == isdrp_pkg::ADDR_WDATA);
   wire logic hit_cnt  = (paddr == isdrp_pkg::ADDR_COUNT);
   wire logic mapped   = hit_ctrl | hit_len | hit_badr | hit_bdat | hit_stat
                       | hit_cmd0 | hit_cmd1 | hit_wdat | hit_cnt;
   wire logic reg_wr   = wr_acc & pready & idle;
   wire logic buf_we   = wr_acc & hit_bdat & idle;
   wire logic start    = wr_acc & hit_ctrl & pwdata[isdrp_pkg::CTRL_START] & idle;
   wire logic done_ack = wr_acc & hit_ctrl & pwdata[isdrp_pkg::CTRL_DONE_ACK];

   // Fields of the current header, same layout for every type
   wire logic [3:0]  f_swap = hdr[0][3:0];
   wire logic [3:0]  f_op   = hdr[1][3:0];
   wire logic [3:0]  f_ctl  = hdr[1][7:4];
   wire logic [15:0] f_idx  = le16(hdr[2], hdr[3]);
   wire logic [15:0] f_sub  = le16(hdr[4], hdr[5]);
   wire logic [15:0] f_len  = le16(hdr[6], hdr[7]);
   wire logic [15:0] f_area = isdrp_pkg::area_size(f_ctl, f_len);
   wire logic is_write = (f_op == isdrp_pkg::OP_WRITE) | (f_op == isdrp_pkg::OP_RW_OR)
                       | (f_op == isdrp_pkg::OP_RW_AND);
   wire logic bad_op   = (f_op > isdrp_pkg::OP_RW_AND);
   wire logic bad_len  = (f_op != isdrp_pkg::OP_NOP)
                       & ((f_len == 16'h0000) | (f_len > f_area)
                       | ((f_ctl == isdrp_pkg::CTL_LAST) & (f_len > isdrp_pkg::LAST_MAX_LEN)));
   wire logic bad_ctl  = (f_ctl > isdrp_pkg::CTL_MAX);
   wire logic bad_swap = (f_swap > isdrp_pkg::SWAP_32);
   wire logic [isdrp_pkg::BUF_AW:0] next_area_end =
      rd_ptr + f_area[isdrp_pkg::BUF_AW:0];
   wire logic overrun  = ({1'b0, next_area_end} > {1'b0, req_len});
   wire logic [isdrp_pkg::BUF_AW:0] wr_len = f_len[isdrp_pkg::BUF_AW:0];
   // Swap groups reverse byte order inside each 2 or 4 byte word
   wire logic [1:0] swap_xor = (cmd_swap == isdrp_pkg::SWAP_16) ? 2'h1 :
                               (cmd_swap == isdrp_pkg::SWAP_32) ? 2'h3 : 2'h0;
   wire logic [isdrp_pkg::BUF_AW:0] data_idx = {rd_ptr[isdrp_pkg::BUF_AW:2],
                                              rd_ptr[1:0] ^ swap_xor};
   wire logic [isdrp_pkg::BUF_AW-1:0] raddr = (state == isdrp_pkg::ST_DATA) ?
      data_idx[isdrp_pkg::BUF_AW-1:0] : rd_ptr[isdrp_pkg::BUF_AW-1:0];
   wire logic at_end   = (rd_ptr >= req_len);
   // Walk events shared by the walker and the status flags
   wire logic in_check = (state == isdrp_pkg::ST_CHECK);
   wire logic chk_bad  = bad_op | bad_ctl | bad_len | bad_swap | overrun;
   wire logic issue    = in_check & ~chk_bad;
   wire logic cmd_fin  = (state == isdrp_pkg::ST_EXEC) & (~cmd_valid | cmd_done);
   wire logic walk_end = (state == isdrp_pkg::ST_WAIT);

   isdrp_mem u_mem (
      .pclk  (pclk),
      .we    (buf_we),
      .waddr (load_addr),
      .wdata (pwdata[7:0]),
      .raddr (raddr),
      .rdata (mem_rdata)
   );

   //////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, unmapped addresses flagged
   wire logic [31:0] rd_mux =
      hit_ctrl ? {31'h0, nonblock} << isdrp_pkg::CTRL_NONBLOCK :
      hit_stat ? {28'h0, err_flag, done_flag, req_ack, req_busy} :
      hit_len  ? {22'h0, req_len} :
      hit_badr ? {23'h0, load_addr} :
      hit_cmd0 ? {cmd_index, 8'h0, cmd_op, cmd_swap} :
      hit_cmd1 ? {cmd_length, cmd_subindex} :
      hit_wdat ? {24'h0, wdata_byte} :
      hit_cnt  ? {16'h0, cmd_count} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_addr <= '0;
         req_len   <= '0;
         nonblock  <= 1'b0;
      end else if (reg_wr) begin
         if (hit_badr) load_addr <= pwdata[isdrp_pkg::BUF_AW-1:0];
         if (buf_we) load_addr <= load_addr + 1'b1;
         if (hit_len) req_len <= pwdata[isdrp_pkg::BUF_AW:0];
         if (hit_ctrl) nonblock <= pwdata[isdrp_pkg::CTRL_NONBLOCK];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Command walker
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state        <= isdrp_pkg::ST_IDLE;
         rd_ptr       <= '0;
         area_end     <= '0;
         wr_end       <= '0;
         hcnt         <= 4'h0;
         rd_phase     <= 1'b0;
         for (int i = 0; i < isdrp_pkg::HDR_BYTES; i++) hdr[i] <= 8'h00;
         cmd_valid    <= 1'b0;
         wdata_valid  <= 1'b0;
         wdata_byte   <= 8'h00;
      end else begin
         wdata_valid <= 1'b0;
         unique case (state)
            isdrp_pkg::ST_IDLE: begin
               if (start) begin
                  state     <= isdrp_pkg::ST_HDR;
                  rd_ptr    <= '0;
                  hcnt      <= 4'h0;
                  rd_phase  <= 1'b0;
               end
            end
            isdrp_pkg::ST_HDR: begin
               if (at_end & (hcnt == 4'h0)) begin
                  state <= isdrp_pkg::ST_WAIT;
               end else if (!rd_phase) begin
                  rd_phase <= 1'b1;
                  rd_ptr   <= rd_ptr + 1'b1;
               end else begin
                  hdr[hcnt[2:0]] <= mem_rdata;
                  rd_phase <= 1'b0;
                  hcnt     <= hcnt + 1'b1;
                  if (hcnt == 4'(isdrp_pkg::HDR_BYTES - 1)) begin
                     state <= isdrp_pkg::ST_CHECK;
                  end
               end
            end
            isdrp_pkg::ST_CHECK: begin
               if (chk_bad) begin
                  state     <= isdrp_pkg::ST_WAIT;
               end else begin
                  area_end  <= next_area_end;
                  wr_end    <= rd_ptr + wr_len;
                  cmd_valid <= (f_op != isdrp_pkg::OP_NOP);
                  state     <= isdrp_pkg::ST_EXEC;
               end
            end
            isdrp_pkg::ST_EXEC: begin
               if (cmd_fin) begin
                  cmd_valid <= 1'b0;
                  rd_phase  <= 1'b0;
                  if (is_write & (cmd_op != isdrp_pkg::OP_NOP)) begin
                     state <= isdrp_pkg::ST_DATA;
                  end else begin
                     rd_ptr <= area_end;
                     hcnt   <= 4'h0;
                     state  <= (f_ctl == isdrp_pkg::CTL_LAST) ? isdrp_pkg::ST_WAIT
                                                             : isdrp_pkg::ST_HDR;
                  end
               end
            end
            isdrp_pkg::ST_DATA: begin
               // One byte every two cycles; the buffer read is registered
               if (rd_ptr >= wr_end) begin
                  rd_ptr <= area_end;
                  hcnt   <= 4'h0;
                  state  <= (f_ctl == isdrp_pkg::CTL_LAST) ? isdrp_pkg::ST_WAIT
                                                          : isdrp_pkg::ST_HDR;
               end else if (!rd_phase) begin
                  rd_phase <= 1'b1;
               end else begin
                  rd_phase    <= 1'b0;
                  wdata_valid <= 1'b1;
                  wdata_byte  <= mem_rdata;
                  rd_ptr      <= rd_ptr + 1'b1;
               end
            end
            isdrp_pkg::ST_WAIT: begin
               state <= isdrp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Fields of the issued command, held for the port unit until it is done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_op       <= 4'h0;
         cmd_swap     <= 4'h0;
         cmd_index    <= 16'h0000;
         cmd_subindex <= 16'h0000;
         cmd_length   <= 16'h0000;
      end else if (issue) begin
         cmd_op       <= f_op;
         cmd_swap     <= f_swap;
         cmd_index    <= f_idx;
         cmd_subindex <= f_sub;
         cmd_length   <= f_len;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Request status seen by software; start only comes while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_ack   <= 1'b0;
         req_busy  <= 1'b0;
         done_flag <= 1'b0;
         err_flag  <= 1'b0;
         cmd_count <= 16'h0000;
      end else if (start) begin
         req_busy  <= 1'b1;
         req_ack   <= 1'b0;
         done_flag <= 1'b0;
         err_flag  <= 1'b0;
         cmd_count <= 16'h0000;
      end else begin
         if (in_check & chk_bad) err_flag <= 1'b1;
         // Non-blocking: acknowledged once the first header checks out
         if (issue & nonblock) req_ack <= 1'b1;
         if (cmd_fin) cmd_count <= cmd_count + 1'b1;
         // Completion sets win over a software clear in the same cycle
         if (walk_end) begin
            req_ack   <= 1'b1;
            req_busy  <= 1'b0;
            done_flag <= 1'b1;
         end else if (done_ack) begin
            done_flag <= 1'b0;
         end
      end
   end
endmodule : isdrp_top
`default_nettype wire

// *** hw/isdrp_pkg.sv ***
// Constants, register map and types of the request parser
package isdrp_pkg;
   // Register byte offsets (APB, one aligned word each)
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_REQ_LEN  = 8'h08;
   localparam logic [7:0] ADDR_BUF_ADDR = 8'h0C;
   localparam logic [7:0] ADDR_BUF_DATA = 8'h10;
   localparam logic [7:0] ADDR_CMD0     = 8'h14;
   localparam logic [7:0] ADDR_CMD1     = 8'h18;
   localparam logic [7:0] ADDR_WDATA    = 8'h1C;
   localparam logic [7:0] ADDR_COUNT    = 8'h20;
   // Control register bits
   localparam int CTRL_START    = 0;
   localparam int CTRL_NONBLOCK = 1;
   localparam int CTRL_DONE_ACK = 2;
   // Request buffer: payload bytes, as large as the carrier allows
   localparam int BUF_AW        = 9;
   localparam int BUF_DEPTH     = 512;
   localparam int HDR_BYTES     = 8;
   // Field codes
   localparam logic [3:0] SWAP_NONE = 4'h0;
   localparam logic [3:0] SWAP_16   = 4'h1;
   localparam logic [3:0] SWAP_32   = 4'h2;
   localparam logic [3:0] OP_NOP    = 4'h0;
   localparam logic [3:0] OP_READ   = 4'h1;
   localparam logic [3:0] OP_WRITE  = 4'h2;
   localparam logic [3:0] OP_RW_OR  = 4'h3;
   localparam logic [3:0] OP_RW_AND = 4'h4;
   localparam logic [3:0] CTL_LAST  = 4'h0;
   localparam logic [3:0] CTL_MAX   = 4'h7;
   localparam logic [15:0] LAST_MAX_LEN = 16'h00E8;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_HDR   = 6'b000010,
      ST_CHECK = 6'b000100,
      ST_EXEC  = 6'b001000,
      ST_DATA  = 6'b010000,
      ST_WAIT  = 6'b100000
   } isdrp_state_t;

   // Data area size from the control nibble: fixed for 1-7, the nested length otherwise
   function automatic logic [15:0] area_size(input logic [3:0] ctl, input logic [15:0] len);
      case (ctl)
         4'h1:    area_size = 16'h0004;
         4'h2:    area_size = 16'h0008;
         4'h3:    area_size = 16'h0010;
         4'h4:    area_size = 16'h0020;
         4'h5:    area_size = 16'h0040;
         4'h6:    area_size = 16'h0080;
         4'h7:    area_size = 16'h00E8;
         default: area_size = len;
      endcase
   endfunction : area_size
endpackage : isdrp_pkg

// *** hw/isdrp_mem.sv ***
// Request byte buffer with registered read data
`timescale 1ns/10ps
`default_nettype none
module isdrp_mem (
   input  wire logic                      pclk,
   input  wire logic                      we,
   input  wire logic [isdrp_pkg::BUF_AW-1:0] waddr,
   input  wire logic [7:0]                wdata,
   input  wire logic [isdrp_pkg::BUF_AW-1:0] raddr,
   output var  logic [7:0]                rdata
);
   logic [7:0] mem [isdrp_pkg::BUF_DEPTH];

   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : isdrp_mem
`default_nettype wire

// *** sim/isdrp_asserts.sv ***
// Checker of the request parser port behaviour
`timescale 1ns/10ps
`default_nettype none
module isdrp_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cmd_valid,
   input wire logic [3:0]  cmd_op,
   input wire logic [3:0]  cmd_swap,
   input wire logic [15:0] cmd_index,
   input wire logic [15:0] cmd_length,
   input wire logic        cmd_done,
   input wire logic        wdata_valid,
   input wire logic        req_ack
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       nonblock;
   logic [3:0] last_op;
   // Mirror of the mode bit, so the ack check knows which mode applies
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nonblock <= 1'b0;
         last_op  <= 4'h0;
      end else begin
         if (psel && penable && pready && pwrite && paddr == isdrp_pkg::ADDR_CTRL)
            nonblock <= pwdata[isdrp_pkg::CTRL_NONBLOCK];
         if (cmd_valid)
            last_op <= cmd_op;
      end
   end
   ////////////////////////////////////////////////////////////
   pready_setup_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   slverr_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   cmd_hold_a: assert property (
      cmd_valid && !cmd_done |=> cmd_valid && $stable(cmd_index) && $stable(cmd_length))
      else $error("command changed before done");
   cmd_release_a: assert property (cmd_valid && cmd_done |=> !cmd_valid)
      else $error("command held after done");
   op_code_a: assert property (
      cmd_valid |-> cmd_op != isdrp_pkg::OP_NOP && cmd_op <= isdrp_pkg::OP_RW_AND)
      else $error("bad command type issued");
   swap_code_a: assert property (cmd_valid |-> cmd_swap <= isdrp_pkg::SWAP_32)
      else $error("bad swap code issued");
   len_range_a: assert property (
      cmd_valid |-> cmd_length != 16'h0000 && cmd_length <= isdrp_pkg::LAST_MAX_LEN)
      else $error("length out of range");
   block_ack_a: assert property (cmd_valid && !nonblock |-> !req_ack)
      else $error("blocking reply before end");
   write_data_a: assert property (wdata_valid |-> last_op >= isdrp_pkg::OP_WRITE)
      else $error("data sent for non-write");
endmodule : isdrp_asserts
bind isdrp_top isdrp_asserts u_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .cmd_valid, .cmd_op, .cmd_swap, .cmd_index, .cmd_length,
   .cmd_done, .wdata_valid, .req_ack);
`default_nettype wire

// *** sim/isdrp_port_model.sv ***
// Port unit model: finishes each issued command after a set delay
`timescale 1ns/10ps
`default_nettype none
module isdrp_port_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       cmd_valid,
   input  wire logic [3:0] dly,
   output var  logic       cmd_done
);
   logic [4:0] cnt;
   // Counter parks above dly so one command never gets two done pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt      <= 5'h00;
         cmd_done <= 1'b0;
      end else begin
         cmd_done <= 1'b0;
         if (!cmd_valid)
            cnt <= 5'h00;
         else if (cnt == {1'b0, dly}) begin
            cmd_done <= 1'b1;
            cnt      <= 5'h1F;
         end else if (cnt < {1'b0, dly})
            cnt <= cnt + 5'h01;
      end
   end
endmodule : isdrp_port_model
`default_nettype wire

// *** sim/isdu_request_parser_bench.sv ***
// Bench of the request parser: chains and modes loaded over APB
`timescale 1ns/10ps
`default_nettype none
module isdu_request_parser_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        cmd_valid, wdata_valid, cmd_done, req_ack, req_busy;
   logic [7:0]  paddr, wdata_byte;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  cmd_op, cmd_swap, dly;
   logic [15:0] cmd_index, cmd_subindex, cmd_length;
   logic [7:0]  msg[$], wq[$];
   logic [55:0] cq[$];
   int          n_mismatch, checks;

   isdrp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cmd_valid, .cmd_op, .cmd_swap, .cmd_index, .cmd_subindex,
      .cmd_length, .wdata_valid, .wdata_byte, .cmd_done, .req_ack, .req_busy);
   isdrp_port_model port (.pclk, .presetn, .cmd_valid, .dly, .cmd_done);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (cmd_valid === 1'b1 && cmd_done === 1'b1)
         cq.push_back({cmd_op, cmd_swap, cmd_index, cmd_subindex, cmd_length});
      if (wdata_valid === 1'b1)
         wq.push_back(wdata_byte);
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic hdr(input logic [7:0] sw, input logic [7:0] tc, input logic [15:0] idx,
                      input logic [15:0] sub, input logic [15:0] len);
      msg.push_back(sw);
      msg.push_back(tc);
      msg.push_back(idx[7:0]);
      msg.push_back(idx[15:8]);
      msg.push_back(sub[7:0]);
      msg.push_back(sub[15:8]);
      msg.push_back(len[7:0]);
      msg.push_back(len[15:8]);
   endtask : hdr

   task automatic run(input logic [31:0] ctl);
      apb(isdrp_pkg::ADDR_REQ_LEN, 1'b1, 32'(msg.size()), rd, err);
      apb(isdrp_pkg::ADDR_BUF_ADDR, 1'b1, 32'h0, rd, err);
      foreach (msg[i]) apb(isdrp_pkg::ADDR_BUF_DATA, 1'b1, {24'h0, msg[i]}, rd, err);
      apb(isdrp_pkg::ADDR_CTRL, 1'b1, ctl, rd, err);
      msg.delete();
   endtask : run

   task automatic wt(input logic v);
      for (int i = 0; i < 3000 && req_busy !== v; i++) @(posedge pclk);
   endtask : wt

   task automatic end_sim();
      if (n_mismatch == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   initial begin
      #200us;
      n_mismatch++;
      end_sim();
   end

   initial begin
      {presetn, psel, penable, pwrite} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      dly = 4'h1;
      n_mismatch = 0;
      checks = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // Blocking: nested write, skipped no-op, final read, ignored tail
      hdr(8'h02, 8'h12, 16'h1234, 16'h0005, 16'h0004);
      for (int i = 1; i < 5; i++) msg.push_back(8'(i * 17));
      hdr(8'h00, 8'h20, 16'hFFFF, 16'hFFFF, 16'h0008);
      repeat (8) msg.push_back(8'hA5);
      hdr(8'h01, 8'h01, 16'hABCD, 16'h0102, 16'h0002);
      msg.push_back(8'hEE);
      msg.push_back(8'hFF);
      hdr(8'h00, 8'h02, 16'h7777, 16'h0000, 16'h0001);
      msg.push_back(8'h99);
      run(32'h1);
      wt(1'b1);
      wt(1'b0);
      chk(cq.size(), 2);
      chk(cq[0], {4'h2, 4'h2, 16'h1234, 16'h0005, 16'h0004});
      chk(cq[1], {4'h1, 4'h1, 16'hABCD, 16'h0102, 16'h0002});
      chk({wq[0], wq[1], wq[2], wq[3]}, 32'h44332211);
      chk(wq.size(), 4);
      apb(isdrp_pkg::ADDR_STATUS, 1'b0, 32'h0, rd, err);
      chk(rd, 32'h6);
      // Non-blocking, slow port unit, chain ended by data end
      cq.delete();
      wq.delete();
      dly <= 4'h8;
      hdr(8'h01, 8'h12, 16'h0010, 16'h0000, 16'h0004);
      for (int i = 0; i < 4; i++) msg.push_back(8'hAA + 8'(i * 17));
      run(32'h3);
      for (int i = 0; i < 3000 && cmd_valid !== 1'b1; i++) @(posedge pclk);
      @(posedge pclk);
      chk(req_ack, 1'b1);
      apb(isdrp_pkg::ADDR_STATUS, 1'b0, 32'h0, rd, err);
      chk(rd, 32'h3);
      wt(1'b0);
      chk(cq.size(), 1);
      chk({wq[0], wq[1], wq[2], wq[3]}, 32'hBBAADDCC);
      apb(isdrp_pkg::ADDR_STATUS, 1'b0, 32'h0, rd, err);
      chk(rd, 32'h6);
      apb(isdrp_pkg::ADDR_CTRL, 1'b1, 32'h6, rd, err);
      apb(isdrp_pkg::ADDR_STATUS, 1'b0, 32'h0, rd, err);
      chk(rd[2], 1'b0);
      // Undefined swap code, then a nested length beyond its area: error, nothing issued
      cq.delete();
      hdr(8'h03, 8'h01, 16'h0001, 16'h0000, 16'h0001);
      msg.push_back(8'h00);
      run(32'h1);
      wt(1'b1);
      wt(1'b0);
      apb(isdrp_pkg::ADDR_STATUS, 1'b0, 32'h0, rd, err);
      chk(rd, 32'hE);
      hdr(8'h00, 8'h11, 16'h0002, 16'h0000, 16'h0005);
      repeat (4) msg.push_back(8'h00);
      run(32'h1);
      wt(1'b1);
      wt(1'b0);
      apb(isdrp_pkg::ADDR_STATUS, 1'b0, 32'h0, rd, err);
      chk(rd, 32'hE);
      chk(cq.size(), 0);
      apb(8'hFC, 1'b0, 32'h0, rd, err);
      chk(err, 1'b1);
      end_sim();
   end
endmodule : isdu_request_parser_bench
`default_nettype wire
